//--- rtl/bsi_pkg.sv
package bsi_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 200000000;
	localparam int STRETCH_MS = 50;
	localparam int STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
	localparam int CLK_LOSS_CYC = 1024;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_LAMPS = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_STANDBY_BIT = 0;
	localparam int CTL_SINGLE_END_BIT = 1;
	localparam int EV_TRIGGER_BIT = 0;
	localparam int EV_OVER_RANGE_BIT = 1;
	localparam int EV_CLK_LOST_BIT = 2;
	localparam int EV_CAPTURE_DONE_BIT = 3;
	localparam int EV_WIDTH = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [1:0] CONTROL_RST = 2'h0;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;

	typedef enum logic [1:0] {
		BSI_IDLE,
		BSI_CAPTURE,
		BSI_UPLOAD
	} bsi_cap_t;

endpackage

//--- rtl/bsi_sync.sv
`timescale 1ns/100ps
module bsi_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // bsi_sync

//--- rtl/bsi_stretch.sv
`timescale 1ns/100ps
module bsi_stretch #(
	parameter int CYCLES = 10000000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// event in, lamp out
	input wire logic event_i,
	output logic lamp_o
);
	logic [31:0] count;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= 32'h0;
		end else if (event_i) begin
			count <= 32'(CYCLES);
		end else if (count != 32'h0) begin
			count <= count - 32'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lamp_o <= 1'b0;
		end else begin
			lamp_o <= event_i || (count > 32'h1);
		end
	end
endmodule // bsi_stretch

//--- rtl/bsi_top.sv
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - standby lamp lit exactly while the board is in standby
// - trigger lamp lights on each low-to-high edge of the trigger input
// - over-range lamp lights when I or Q sample exceeds full scale
// - clock lamp blinks at even duty only while converter clock is seen
// - power lamp lit while supply present and board not in standby
// - upload lamp lit while captured data goes to the host, no capture runs and board not in standby
// - capture lamp lit while samples are written into the buffers and board not in standby
// - idle lamp lit while capture system neither samples nor uploads and board not in standby
// - differential mode: two byte buses, each with a differential strobe
// - single-ended mode: four byte buses, each with its own strobe
module bsi_top #(
	parameter int STRETCH_CYC = bsi_pkg::STRETCH_CYC,
	parameter int BLINK_CYC = bsi_pkg::BLINK_CYC,
	parameter int CLK_LOSS_CYC = bsi_pkg::CLK_LOSS_CYC
) (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// avalon-mm slave
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// board state inputs
	input wire logic TRIGGER_I,
	input wire logic OVER_RANGE_I_I,
	input wire logic OVER_RANGE_Q_I,
	input wire logic CONV_CLK_TICK_I,
	input wire logic SUPPLY_OK_I,
	input wire logic CAPTURE_BUSY_I,
	input wire logic UPLOAD_BUSY_I,
	// expansion header data
	input wire logic [31:0] HDR_DATA_I,
	input wire logic HDR_STROBE_I,
	output logic [31:0] HDR_DATA_O,
	output logic [3:0] HDR_STROBE_O,
	output logic HDR_DIFF_MODE_O,
	// lamps
	output logic STANDBY_LAMP_O,
	output logic TRIGGER_EVENT_LAMP_O,
	output logic OVER_RANGE_LAMP_O,
	output logic CLOCK_LAMP_O,
	output logic POWER_LAMP_O,
	output logic UPLOAD_LAMP_O,
	output logic CAPTURE_LAMP_O,
	output logic IDLE_LAMP_O,
	// interrupt
	output logic IRQ_O
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [6:0] pins_s;
	logic trig_s;
	logic ovr_i_s;
	logic ovr_q_s;
	logic cclk_s;
	logic supply_s;
	logic cap_s;
	logic upl_s;

	bsi_sync #(
		.WIDTH(7)
	) u_sync (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.d_i({TRIGGER_I, OVER_RANGE_I_I, OVER_RANGE_Q_I, CONV_CLK_TICK_I,
			SUPPLY_OK_I, CAPTURE_BUSY_I, UPLOAD_BUSY_I}),
		.q_o(pins_s)
	);

	assign {trig_s, ovr_i_s, ovr_q_s, cclk_s, supply_s, cap_s, upl_s} = pins_s;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [1:0] control;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	logic wr_ok;
	logic standby;
	logic single_end;
	logic rd_done;

	// writes land in the request cycle; a read waits one cycle so that its
	// registered data already stand when waitrequest drops
	assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_done;
	assign wr_ok = AVS_WRITE_I && !AVS_READ_I;

	// one write decode shared by every writable register
	function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
		input logic [3:0] ofs);
		return wr && addr == ofs;
	endfunction

	assign standby = control[bsi_pkg::CTL_STANDBY_BIT];
	assign single_end = control[bsi_pkg::CTL_SINGLE_END_BIT];

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			control <= bsi_pkg::CONTROL_RST;
		end else if (wr_hit(wr_ok, AVS_ADDRESS_I,
			bsi_pkg::OFS_CONTROL)) begin
			control <= AVS_WRITEDATA_I[1:0];
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			irq_mask <= bsi_pkg::IRQ_MASK_RST;
		end else if (wr_hit(wr_ok, AVS_ADDRESS_I,
			bsi_pkg::OFS_IRQ_MASK)) begin
			irq_mask <= AVS_WRITEDATA_I[3:0];
		end
	end

	// ------------------------------------------------------------
	// read handshake
	// ------------------------------------------------------------
	// the read mux loads the word in the first cycle of a read; the next
	// cycle returns it with waitrequest low, so every read costs one wait
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			rd_done <= 1'b0;
		end else begin
			rd_done <= AVS_READ_I && !rd_done;
		end
	end

	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	logic trig_d;
	logic cclk_d;
	logic cap_d;
	logic trig_rise;
	logic ovr_any;
	logic cclk_edge;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			trig_d <= 1'b0;
			cclk_d <= 1'b0;
			cap_d <= 1'b0;
		end else begin
			trig_d <= trig_s;
			cclk_d <= cclk_s;
			cap_d <= cap_s;
		end
	end

	assign trig_rise = trig_s && !trig_d;
	assign ovr_any = ovr_i_s || ovr_q_s;
	// either tick edge counts, so a divided clock is seen while its half period is no longer than CLK_LOSS_CYC cycles
	assign cclk_edge = cclk_s != cclk_d;

	// ------------------------------------------------------------
	// clock presence and blink
	// ------------------------------------------------------------
	logic [31:0] loss_cnt;
	logic clk_present;
	logic clk_present_d;
	logic [31:0] blink_cnt;
	logic blink;

	// presence is held until no converter-clock edge for the loss window
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			loss_cnt <= 32'h0;
		end else if (cclk_edge) begin
			loss_cnt <= 32'(CLK_LOSS_CYC);
		end else if (loss_cnt != 32'h0) begin
			loss_cnt <= loss_cnt - 32'h1;
		end
	end

	assign clk_present = loss_cnt != 32'h0;

	// equal halves: each phase lasts BLINK_CYC cycles
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			blink_cnt <= 32'h0;
			blink <= 1'b0;
			clk_present_d <= 1'b0;
		end else begin
			clk_present_d <= clk_present;
			if (!clk_present) begin
				blink_cnt <= 32'h0;
				blink <= 1'b0;
			end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
				blink_cnt <= 32'h0;
				blink <= !blink;
			end else begin
				blink_cnt <= blink_cnt + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// capture state
	// ------------------------------------------------------------
	bsi_pkg::bsi_cap_t cap_state;
	bsi_pkg::bsi_cap_t next_cap_state;

	// capture takes precedence if both busy inputs are ever seen together
	always_comb begin
		case ({cap_s, upl_s})
			2'b10, 2'b11: next_cap_state = bsi_pkg::BSI_CAPTURE;
			2'b01: next_cap_state = bsi_pkg::BSI_UPLOAD;
			2'b00: next_cap_state = bsi_pkg::BSI_IDLE;
			default: next_cap_state = bsi_pkg::BSI_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			cap_state <= bsi_pkg::BSI_IDLE;
		end else begin
			cap_state <= next_cap_state;
		end
	end

	// ------------------------------------------------------------
	// stretched lamps
	// ------------------------------------------------------------
	logic trig_lamp;
	logic ovr_lamp;

	bsi_stretch #(
		.CYCLES(STRETCH_CYC)
	) u_trig_stretch (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.event_i(trig_rise),
		.lamp_o(trig_lamp)
	);

	bsi_stretch #(
		.CYCLES(STRETCH_CYC)
	) u_ovr_stretch (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.event_i(ovr_any),
		.lamp_o(ovr_lamp)
	);

	// ------------------------------------------------------------
	// lamp drivers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			STANDBY_LAMP_O <= 1'b0;
			TRIGGER_EVENT_LAMP_O <= 1'b0;
			OVER_RANGE_LAMP_O <= 1'b0;
			CLOCK_LAMP_O <= 1'b0;
			POWER_LAMP_O <= 1'b0;
			UPLOAD_LAMP_O <= 1'b0;
			CAPTURE_LAMP_O <= 1'b0;
			IDLE_LAMP_O <= 1'b0;
		end else begin
			STANDBY_LAMP_O <= standby;
			TRIGGER_EVENT_LAMP_O <= trig_lamp;
			OVER_RANGE_LAMP_O <= ovr_lamp;
			CLOCK_LAMP_O <= blink;
			POWER_LAMP_O <= supply_s && !standby;
			UPLOAD_LAMP_O <= !standby &&
				cap_state == bsi_pkg::BSI_UPLOAD;
			CAPTURE_LAMP_O <= !standby &&
				cap_state == bsi_pkg::BSI_CAPTURE;
			IDLE_LAMP_O <= !standby &&
				cap_state == bsi_pkg::BSI_IDLE;
		end
	end

	// ------------------------------------------------------------
	// expansion header data paths
	// ------------------------------------------------------------
	// HDR_DATA_I carries up to four byte lanes; diff mode uses lanes 0..1
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			HDR_DATA_O <= 32'h0;
			HDR_STROBE_O <= 4'h0;
			HDR_DIFF_MODE_O <= 1'b1;
		end else begin
			HDR_DIFF_MODE_O <= !single_end;
			if (single_end) begin
				HDR_DATA_O <= HDR_DATA_I;
				HDR_STROBE_O <= {4{HDR_STROBE_I}};
			end else begin
				HDR_DATA_O <= {16'h0, HDR_DATA_I[15:0]};
				HDR_STROBE_O <= {2'h0, {2{HDR_STROBE_I}}};
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	logic [3:0] ev;
	logic [3:0] clr;

	always_comb begin
		ev = 4'h0;
		ev[bsi_pkg::EV_TRIGGER_BIT] = trig_rise;
		ev[bsi_pkg::EV_OVER_RANGE_BIT] = ovr_any;
		ev[bsi_pkg::EV_CLK_LOST_BIT] = clk_present_d && !clk_present;
		ev[bsi_pkg::EV_CAPTURE_DONE_BIT] = cap_d && !cap_s;
	end
	assign clr = wr_hit(wr_ok, AVS_ADDRESS_I, bsi_pkg::OFS_IRQ_STATUS) ?
		AVS_WRITEDATA_I[3:0] : 4'h0;

	// a new event wins over a simultaneous write-one-to-clear
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			irq_status <= 4'h0;
		end else begin
			irq_status <= (irq_status & ~clr) | ev;
		end
	end

	// level output straight from the status and mask flops
	assign IRQ_O = |(irq_status & irq_mask);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// loaded in the wait cycle of a read, held until the next read
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			AVS_READDATA_O <= 32'h0;
		end else if (AVS_READ_I && !rd_done) begin
			case (AVS_ADDRESS_I)
				bsi_pkg::OFS_CONTROL: AVS_READDATA_O <= {30'h0, control};
				bsi_pkg::OFS_LAMPS: AVS_READDATA_O <= {23'h0, clk_present,
					IDLE_LAMP_O, CAPTURE_LAMP_O, UPLOAD_LAMP_O, POWER_LAMP_O,
					CLOCK_LAMP_O, OVER_RANGE_LAMP_O, TRIGGER_EVENT_LAMP_O,
					STANDBY_LAMP_O};
				bsi_pkg::OFS_IRQ_STATUS: AVS_READDATA_O <= {28'h0, irq_status};
				bsi_pkg::OFS_IRQ_MASK: AVS_READDATA_O <= {28'h0, irq_mask};
				default: AVS_READDATA_O <= 32'h0;
			endcase
		end
	end
endmodule // bsi_top

//--- verif/bsi_assertions.sv
`timescale 1ns/100ps
module bsi_checker #(
	parameter int STRETCH_CYC = 8,
	parameter int CLK_LOSS_CYC = 16
) (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// board state
	input wire logic TRIGGER_I,
	input wire logic OVER_RANGE_I_I,
	input wire logic OVER_RANGE_Q_I,
	input wire logic CONV_CLK_TICK_I,
	input wire logic SUPPLY_OK_I,
	input wire logic CAPTURE_BUSY_I,
	input wire logic UPLOAD_BUSY_I,
	// lamps
	input wire logic STANDBY_LAMP_O,
	input wire logic TRIGGER_EVENT_LAMP_O,
	input wire logic OVER_RANGE_LAMP_O,
	input wire logic CLOCK_LAMP_O,
	input wire logic POWER_LAMP_O,
	input wire logic UPLOAD_LAMP_O,
	input wire logic CAPTURE_LAMP_O,
	input wire logic IDLE_LAMP_O,
	// header
	input wire logic [3:0] HDR_STROBE_O,
	input wire logic HDR_DIFF_MODE_O
);
	int trg_run;
	int still_run;
	logic tick_q;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// ----------------------------------------
	// run counters, long counts need no repetition
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			trg_run <= 0;
			still_run <= 0;
			tick_q <= 1'b0;
		end else begin
			trg_run <= TRIGGER_EVENT_LAMP_O ? trg_run + 1 : 0;
			tick_q <= CONV_CLK_TICK_I;
			if (tick_q != CONV_CLK_TICK_I) begin
				still_run <= 0;
			end else if (still_run < 1000) begin
				still_run <= still_run + 1;
			end
		end
	end
	trg_lamp_a: assert property ($rose(TRIGGER_I) |->
		##[1:5] TRIGGER_EVENT_LAMP_O) else $error("trigger lamp late");
	trg_hold_a: assert property ($fell(TRIGGER_EVENT_LAMP_O) |->
		trg_run >= STRETCH_CYC) else $error("trigger lamp short");
	ovr_lamp_a: assert property ($rose(OVER_RANGE_I_I || OVER_RANGE_Q_I)
		|-> ##[1:5] OVER_RANGE_LAMP_O) else $error("over-range lamp late");
	cap_lamp_a: assert property ($rose(CAPTURE_BUSY_I) && !STANDBY_LAMP_O
		|-> ##[1:5] CAPTURE_LAMP_O) else $error("capture lamp late");
	upl_lamp_a: assert property ($fell(CAPTURE_BUSY_I) && UPLOAD_BUSY_I
		&& !STANDBY_LAMP_O |-> ##[1:5] UPLOAD_LAMP_O)
		else $error("upload lamp late");
	one_state_a: assert property ($onehot0({IDLE_LAMP_O,
		CAPTURE_LAMP_O, UPLOAD_LAMP_O})) else $error("two state lamps");
	idle_lamp_a: assert property ((!STANDBY_LAMP_O && !CAPTURE_BUSY_I
		&& !UPLOAD_BUSY_I) [*6] |-> IDLE_LAMP_O) else $error("idle dark");
	pwr_off_a: assert property (!SUPPLY_OK_I [*6] |->
		!POWER_LAMP_O) else $error("power lamp without supply");
	clk_off_a: assert property (still_run > CLK_LOSS_CYC + 6 |->
		!CLOCK_LAMP_O) else $error("clock lamp without clock");
	one_lit_a: assert property (!STANDBY_LAMP_O && !$past(RST_I) |->
		$onehot({IDLE_LAMP_O, CAPTURE_LAMP_O, UPLOAD_LAMP_O}))
		else $error("state lamps not one-hot");
	diff_strb_a: assert property (HDR_DIFF_MODE_O |->
		HDR_STROBE_O[3:2] == 2'h0) else $error("upper strobes in diff mode");
endmodule // bsi_checker

bind bsi_top bsi_checker #(.STRETCH_CYC(STRETCH_CYC),
	.CLK_LOSS_CYC(CLK_LOSS_CYC)) chk_i (.*);

//--- verif/bsi_partner.sv
`timescale 1ns/100ps
module bsi_partner #(
	parameter logic [31:0] WORD = 32'h5A3C96E1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// converter clock tick
	input wire logic tick_en_i,
	output logic tick_o,
	// header source
	input wire logic hdr_en_i,
	output logic [31:0] data_o,
	output logic strobe_o
);
	logic [1:0] div;
	// divided clock stands still while the converter clock is lost
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div <= 2'h0;
			tick_o <= 1'b0;
		end else if (tick_en_i) begin
			div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
			tick_o <= (div == 2'h2) ? ~tick_o : tick_o;
		end
	end
	// idle lanes show the inverse word so stale data cannot match
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_o <= ~WORD;
			strobe_o <= 1'b0;
		end else begin
			data_o <= hdr_en_i ? WORD : ~WORD;
			strobe_o <= hdr_en_i;
		end
	end
endmodule // bsi_partner

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
	localparam logic [31:0] WORD = 32'h5A3C96E1;
	logic CLK_SYS_I = 1'b0;
	logic RST_I = 1'b1;
	logic [3:0] AVS_ADDRESS_I = 4'h0;
	logic AVS_READ_I = 1'b0;
	logic AVS_WRITE_I = 1'b0;
	logic [31:0] AVS_WRITEDATA_I = 32'h0;
	logic TRIGGER_I = 1'b0;
	logic OVER_RANGE_I_I = 1'b0;
	logic OVER_RANGE_Q_I = 1'b0;
	logic SUPPLY_OK_I = 1'b1;
	logic CAPTURE_BUSY_I = 1'b0;
	logic UPLOAD_BUSY_I = 1'b0;
	logic tick_en = 1'b1;
	logic hdr_en = 1'b0;
	logic [31:0] AVS_READDATA_O, HDR_DATA_I, HDR_DATA_O, rdata;
	logic [3:0] HDR_STROBE_O;
	logic AVS_WAITREQUEST_O, CONV_CLK_TICK_I, HDR_STROBE_I, HDR_DIFF_MODE_O;
	logic STANDBY_LAMP_O, TRIGGER_EVENT_LAMP_O, OVER_RANGE_LAMP_O, IRQ_O;
	logic CLOCK_LAMP_O, POWER_LAMP_O, UPLOAD_LAMP_O, CAPTURE_LAMP_O;
	logic IDLE_LAMP_O, irq_a;
	int n_errors = 0;
	int comparisons = 0;
	int cnt;

	always #2.5 CLK_SYS_I = ~CLK_SYS_I;

	bsi_top #(.STRETCH_CYC(8), .BLINK_CYC(4), .CLK_LOSS_CYC(16)) dut (.*);
	bsi_partner #(.WORD(WORD)) far (.clk_i(CLK_SYS_I), .rst_i(RST_I),
		.tick_en_i(tick_en), .tick_o(CONV_CLK_TICK_I), .hdr_en_i(hdr_en),
		.data_o(HDR_DATA_I), .strobe_o(HDR_STROBE_I));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task end_sim;
		$display("mismatches %0d of %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			$display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
			n_errors++;
		end
	endtask
	// ends on the edge: reads see the values settled before it
	task cyc(input int n);
		repeat (n) @(posedge CLK_SYS_I);
	endtask
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK_SYS_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= wr;
		AVS_READ_I <= !wr;
		do begin
			@(posedge CLK_SYS_I);
			n++;
		end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
		if (AVS_WAITREQUEST_O !== 1'b0) begin
			n_errors++;
			end_sim;
		end else begin
			// read data are taken at the edge that sees waitrequest low
			rdata = AVS_READDATA_O;
			AVS_WRITE_I <= 1'b0;
			AVS_READ_I <= 1'b0;
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk("idle", 1'b1, IDLE_LAMP_O);
		chk("diff", 1'b1, HDR_DIFF_MODE_O);
		bus(1'b0, bsi_pkg::OFS_CONTROL, 32'h0);
		chk("ctl", bsi_pkg::CONTROL_RST, rdata);
		bus(1'b0, bsi_pkg::OFS_IRQ_MASK, 32'h0);
		chk("mask", bsi_pkg::IRQ_MASK_RST, rdata);
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rdata);
	endtask
	task t_standby;
		bus(1'b1, bsi_pkg::OFS_CONTROL, 32'h1);
		cyc(6);
		chk("stby", 1'b1, STANDBY_LAMP_O);
		chk("pwr", 1'b0, POWER_LAMP_O);
		chk("idle", 1'b0, IDLE_LAMP_O);
		bus(1'b1, bsi_pkg::OFS_CONTROL, 32'h0);
		cyc(6);
		chk("stby", 1'b0, STANDBY_LAMP_O);
		chk("pwr", 1'b1, POWER_LAMP_O);
		@(posedge CLK_SYS_I);
		SUPPLY_OK_I <= 1'b0;
		cyc(8);
		chk("pwr", 1'b0, POWER_LAMP_O);
		SUPPLY_OK_I <= 1'b1;
	endtask
	task t_capture;
		@(posedge CLK_SYS_I);
		CAPTURE_BUSY_I <= 1'b1;
		UPLOAD_BUSY_I <= 1'b1;
		cyc(6);
		chk("cap", 3'h2, {IDLE_LAMP_O, CAPTURE_LAMP_O, UPLOAD_LAMP_O});
		CAPTURE_BUSY_I <= 1'b0;
		cyc(6);
		chk("upl", 3'h1, {IDLE_LAMP_O, CAPTURE_LAMP_O, UPLOAD_LAMP_O});
		UPLOAD_BUSY_I <= 1'b0;
		cyc(6);
		chk("idle", 3'h4, {IDLE_LAMP_O, CAPTURE_LAMP_O, UPLOAD_LAMP_O});
	endtask
	task t_events;
		bus(1'b1, bsi_pkg::OFS_IRQ_STATUS, 32'hF);
		TRIGGER_I <= 1'b1;
		cyc(1);
		TRIGGER_I <= 1'b0;
		cyc(5);
		chk("trg", 1'b1, TRIGGER_EVENT_LAMP_O);
		bus(1'b0, bsi_pkg::OFS_IRQ_STATUS, 32'h0);
		chk("st", 1'b1, rdata[0]);
		irq_a = IRQ_O;
		bus(1'b1, bsi_pkg::OFS_IRQ_MASK, 32'hF);
		cyc(1);
		chk("irq", 1'b1, irq_a ^ IRQ_O);
		cyc(12);
		chk("trg", 1'b0, TRIGGER_EVENT_LAMP_O);
		OVER_RANGE_Q_I <= 1'b1;
		cyc(1);
		OVER_RANGE_Q_I <= 1'b0;
		OVER_RANGE_I_I <= 1'b1;
		cyc(1);
		OVER_RANGE_I_I <= 1'b0;
		cyc(4);
		chk("ovr", 1'b1, OVER_RANGE_LAMP_O);
		cyc(16);
		chk("ovr", 1'b0, OVER_RANGE_LAMP_O);
		bus(1'b1, bsi_pkg::OFS_IRQ_STATUS, 32'hF);
		bus(1'b0, bsi_pkg::OFS_IRQ_STATUS, 32'h0);
		chk("st", 32'h0, rdata);
		chk("irq", 1'b0, IRQ_O);
	endtask
	task t_clock;
		cnt = 0;
		repeat (32) begin
			cyc(1);
			cnt += (CLOCK_LAMP_O === 1'b1);
		end
		chk("blink", 16, cnt);
		tick_en <= 1'b0;
		cyc(40);
		chk("clk", 1'b0, CLOCK_LAMP_O);
		tick_en <= 1'b1;
	endtask
	task t_header;
		hdr_en <= 1'b1;
		cyc(3);
		chk("strb", 4'h3, HDR_STROBE_O);
		chk("lanes", WORD[15:0], HDR_DATA_O[15:0]);
		chk("upper", 16'h0, HDR_DATA_O[31:16]);
		bus(1'b1, bsi_pkg::OFS_CONTROL, 32'h2);
		cyc(3);
		chk("diff", 1'b0, HDR_DIFF_MODE_O);
		chk("strb", 4'hF, HDR_STROBE_O);
		chk("lanes", WORD, HDR_DATA_O);
	endtask

	initial begin
		repeat (2) @(posedge CLK_SYS_I);
		RST_I <= 1'b0;
		cyc(2);
		t_reset;
		t_standby;
		t_capture;
		t_events;
		t_clock;
		t_header;
		end_sim;
	end
endmodule // tb
